// ===== hw/output_enable_control.sv
// Output enable and disabled-state control for an eight-output clock buffer, with an AXI4-Lite register port.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`include "oe_ctrl_regs.svh"
`default_nettype none
// Summary of operation
// R1: Code 00 pull low, 01 diff low, 11 high-Z
// R2: Second code pin is code bit one
// R3: Serial mode: second pin is open-drain data
// R4: Enable low drives output active
// R5: Enable high selects coded disabled state
// R6: Enable changes apply after four cycles
// R7: Mode pin chooses pins or serial bus
// R8: Mode pin held; change needs power cycle
// R9: Delay line runs on selected clock
module output_enable_control import oe_ctrl_pkg::*; #(
	parameter int NUM_OUT = 8,
	parameter int DELAY_CYCLES = `ENABLE_DELAY_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic mode_select_in,
	input wire logic [NUM_OUT-1:0] per_output_enable_n_in,
	input wire logic disabled_state_code_bit0_in,
	input wire logic disabled_state_code_bit1_in,
	output logic disabled_state_code_bit1_out,
	output logic disabled_state_code_bit1_oe_out,
	output drive_state_t [NUM_OUT-1:0] drive_state_out,
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [`AXI_ADDR_W-1:0] axi_awaddr_in,
	input wire logic [2:0] axi_awprot_in,
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	output logic [1:0] axi_bresp_out,
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	input wire logic [`AXI_ADDR_W-1:0] axi_araddr_in,
	input wire logic [2:0] axi_arprot_in,
	output logic axi_rvalid_out,
	input wire logic axi_rready_in,
	output logic [31:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic drive_state_t decode_code(input logic [1:0] code);
		drive_state_t s;
		case (code)
			`CODE_PULL_LOW: s = DRIVE_PULL_LOW;
			`CODE_DIFF_LOW: s = DRIVE_DIFF_LOW;
			`CODE_HIGH_Z: s = DRIVE_HIGH_Z;
			default: s = DRIVE_RESERVED;
		endcase
		return s;
	endfunction

	function automatic logic addr_is(input logic [`AXI_ADDR_W-1:0] addr, input logic [`AXI_ADDR_W-1:0] offs);
		return addr[`AXI_ADDR_W-1:2] == offs[`AXI_ADDR_W-1:2];
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NUM_OUT-1:0] en_n_sync;
	logic [2:0] misc_sync;
	logic mode_pin_sync;
	logic code0_sync;
	logic code1_sync;

	level_sync #(.WIDTH(NUM_OUT)) u_en_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(per_output_enable_n_in),
		.sync_out(en_n_sync)
	);

	level_sync #(.WIDTH(3)) u_misc_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in({mode_select_in, disabled_state_code_bit1_in, disabled_state_code_bit0_in}),
		.sync_out(misc_sync)
	);

	assign mode_pin_sync = misc_sync[2];
	assign code1_sync = misc_sync[1];
	assign code0_sync = misc_sync[0];

	// ----------------------------------------
	// Mode capture
	// ----------------------------------------
	// The mode is caught once, after the synchroniser has settled, and then held until the next reset,
	// since a changing mode pin is only honoured across a power cycle.
	logic [1:0] settle_cnt;
	logic mode_valid;
	logic serial_mode;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_cnt <= 2'h0;
			mode_valid <= 1'b0;
			serial_mode <= 1'b0;
		end else if (!mode_valid) begin
			settle_cnt <= settle_cnt + 2'h1;
			if (settle_cnt == `MODE_SETTLE_COUNT) begin
				mode_valid <= 1'b1;
				serial_mode <= mode_pin_sync; // see R7 see R8
			end
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [31:0] status;
	enable_ctrl_t pin_ctrl;
	enable_ctrl_t bus_ctrl;
	enable_ctrl_t sel_ctrl;
	logic [NUM_OUT-1:0] en_src;
	logic [NUM_OUT-1:0] en_eff;

	assign pin_ctrl.enable = ~en_n_sync; // see R4 see R5
	assign pin_ctrl.code = {code1_sync, code0_sync}; // see R2
	assign bus_ctrl.enable = ctrl[`CTRL_EN_LSB +: NUM_OUT];
	assign bus_ctrl.code = ctrl[`CTRL_CODE_LSB +: 2];
	assign sel_ctrl = serial_mode ? bus_ctrl : pin_ctrl; // see R7
	assign en_src = mode_valid ? sel_ctrl.enable : '0;

	// ----------------------------------------
	// Enable delay and output state
	// ----------------------------------------
	// The delay line runs on the buffer's selected clock, so a new enable lands on a clock edge
	// and the output never shows a runt pulse.
	enable_delay #(.WIDTH(NUM_OUT), .DEPTH(DELAY_CYCLES)) u_delay (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.enable_in(en_src),
		.enable_out(en_eff)
	); // see R6 see R9

	drive_state_t [NUM_OUT-1:0] next_drive;

	for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
		assign next_drive[i] = en_eff[i] ? DRIVE_ACTIVE : decode_code(sel_ctrl.code); // see R1 see R4 see R5
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drive_state_out <= '{default: DRIVE_HIGH_Z};
		end else begin
			drive_state_out <= next_drive;
		end
	end

	// ----------------------------------------
	// Serial data pin
	// ----------------------------------------
	// The data line is only ever pulled low; the enable alone decides whether it is driven.
	logic next_sda_oe;

	assign next_sda_oe = mode_valid && serial_mode && ctrl[`CTRL_SDA_LOW_BIT];

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			disabled_state_code_bit1_oe_out <= 1'b0;
			disabled_state_code_bit1_out <= 1'b0;
		end else begin
			disabled_state_code_bit1_oe_out <= next_sda_oe; // see R3
			disabled_state_code_bit1_out <= 1'b0; // see R3
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_hs;
	logic w_hs;
	logic b_hs;
	logic ar_hs;
	logic r_hs;
	logic aw_held;
	logic w_held;
	logic [`AXI_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_ctrl;
	logic rd_ctrl;
	logic rd_status;
	logic [31:0] next_ctrl;
	logic [31:0] next_rdata;

	assign aw_hs = axi_awvalid_in && axi_awready_out;
	assign w_hs = axi_wvalid_in && axi_wready_out;
	assign b_hs = axi_bvalid_out && axi_bready_in;
	assign ar_hs = axi_arvalid_in && axi_arready_out;
	assign r_hs = axi_rvalid_out && axi_rready_in;
	assign do_write = aw_held && w_held && !axi_bvalid_out;
	assign wr_ctrl = addr_is(aw_addr, `REG_CTRL_OFFSET);
	assign rd_ctrl = addr_is(axi_araddr_in, `REG_CTRL_OFFSET);
	assign rd_status = addr_is(axi_araddr_in, `REG_STATUS_OFFSET);

	// Bits outside the mask stay zero whatever software writes, so reads never show stray state.
	localparam logic [31:0] CTRL_WMASK_BITS = `CTRL_WMASK;

	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign next_ctrl[b*8 +: 8] = w_strb[b] ? (w_data[b*8 +: 8] & CTRL_WMASK_BITS[b*8 +: 8])
			: ctrl[b*8 +: 8];
	end

	assign status = 32'(en_eff) << `STAT_EN_LSB
		| 32'(sel_ctrl.code) << `STAT_CODE_LSB
		| 32'(serial_mode) << `STAT_MODE_BIT
		| 32'(code0_sync) << `STAT_SCL_BIT
		| 32'(code1_sync) << `STAT_SDA_BIT
		| 32'(sel_ctrl.code == `CODE_RESERVED) << `STAT_RSVD_BIT;

	assign next_rdata = rd_ctrl ? ctrl : (rd_status ? status : 32'h0000_0000);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			axi_awready_out <= 1'b1;
		end else if (aw_hs) begin
			aw_held <= 1'b1;
			aw_addr <= axi_awaddr_in;
			axi_awready_out <= 1'b0;
		end else if (b_hs) begin
			aw_held <= 1'b0;
			axi_awready_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			axi_wready_out <= 1'b1;
		end else if (w_hs) begin
			w_held <= 1'b1;
			w_data <= axi_wdata_in;
			w_strb <= axi_wstrb_in;
			axi_wready_out <= 1'b0;
		end else if (b_hs) begin
			w_held <= 1'b0;
			axi_wready_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl <= `CTRL_RESET;
			axi_bvalid_out <= 1'b0;
			axi_bresp_out <= `AXI_RESP_OKAY;
		end else if (do_write) begin
			ctrl <= wr_ctrl ? next_ctrl : ctrl;
			axi_bvalid_out <= 1'b1;
			axi_bresp_out <= (wr_ctrl || addr_is(aw_addr, `REG_STATUS_OFFSET)) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (b_hs) begin
			axi_bvalid_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			axi_arready_out <= 1'b1;
			axi_rvalid_out <= 1'b0;
			axi_rdata_out <= 32'h0000_0000;
			axi_rresp_out <= `AXI_RESP_OKAY;
		end else if (ar_hs) begin
			axi_arready_out <= 1'b0;
			axi_rvalid_out <= 1'b1;
			axi_rdata_out <= next_rdata;
			axi_rresp_out <= (rd_ctrl || rd_status) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (r_hs) begin
			axi_arready_out <= 1'b1;
			axi_rvalid_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_R1_DECODE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R1
		!en_eff[0] && sel_ctrl.code == `CODE_DIFF_LOW |=> drive_state_out[0] == DRIVE_DIFF_LOW)
		else $error("Disabled output does not follow the differential-low code.");

	AST_R2_CODE_PIN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R2
		mode_valid && !serial_mode && !en_eff[1] |=>
			drive_state_out[1] == decode_code({$past(code1_sync), $past(code0_sync)}))
		else $error("Disabled state does not follow both code pins in pin mode.");

	AST_R3_OPEN_DRAIN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R3
		disabled_state_code_bit1_oe_out |-> serial_mode && !disabled_state_code_bit1_out)
		else $error("Data pin driven outside serial mode or driven high.");

	AST_R4_ACTIVE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R4
		en_eff[2] |=> drive_state_out[2] == DRIVE_ACTIVE)
		else $error("Enabled output is not driven active.");

	AST_R5_DISABLED: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R5
		!en_eff[3] |=> drive_state_out[3] != DRIVE_ACTIVE)
		else $error("Disabled output is still driven active.");

	AST_R6_DELAY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R6
		$changed(en_src) |-> ##4 en_eff == $past(en_src, 4))
		else $error("Enable change did not land after four cycles.");

	AST_R7_MODE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R7
		mode_valid && $past(mode_valid) |-> $stable(serial_mode) ##1 $stable(serial_mode))
		else $error("Control mode changed after capture.");

	AST_R9_NO_EARLY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R9
		$changed(en_eff) |-> en_eff == $past(en_src, 4) && $past(en_src, 4) != $past(en_src, 5))
		else $error("Enable moved without a source change four cycles earlier.");
endmodule
`default_nettype wire

// ===== hw/oe_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the output enable control.
`ifndef OE_CTRL_REGS_SVH
`define OE_CTRL_REGS_SVH
// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define AXI_ADDR_W 4
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL_OFFSET 4'h0
`define REG_STATUS_OFFSET 4'h4
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_EN_LSB 0
`define CTRL_CODE_LSB 8
`define CTRL_SDA_LOW_BIT 16
`define CTRL_WMASK 32'h0001_03FF
`define CTRL_RESET 32'h0000_03FF
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STAT_EN_LSB 0
`define STAT_CODE_LSB 8
`define STAT_MODE_BIT 12
`define STAT_SCL_BIT 13
`define STAT_SDA_BIT 14
`define STAT_RSVD_BIT 15
// ----------------------------------------
// Disabled-state codes and timing
// ----------------------------------------
`define CODE_PULL_LOW 2'h0
`define CODE_DIFF_LOW 2'h1
`define CODE_RESERVED 2'h2
`define CODE_HIGH_Z 2'h3
`define ENABLE_DELAY_CYCLES 4
`define MODE_SETTLE_COUNT 2'h2
`endif

// ===== hw/oe_ctrl_pkg.sv
// Types shared by the output enable control.
`default_nettype none
package oe_ctrl_pkg;
	typedef enum logic [2:0] {
		DRIVE_ACTIVE,
		DRIVE_PULL_LOW,
		DRIVE_DIFF_LOW,
		DRIVE_HIGH_Z,
		DRIVE_RESERVED
	} drive_state_t;
	typedef struct packed {
		logic [7:0] enable;
		logic [1:0] code;
	} enable_ctrl_t;
endpackage
`default_nettype wire

// ===== hw/level_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule
`default_nettype wire

// ===== hw/enable_delay.sv
// Fixed-depth delay line that holds back enable changes by a whole number of clock cycles.
`default_nettype none
module enable_delay #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] enable_in,
	output logic [WIDTH-1:0] enable_out
);
	logic [WIDTH-1:0] stage [DEPTH];

	// Reset leaves every output disabled, so nothing toggles before the mode is known.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage[0] <= '0;
		end else begin
			stage[0] <= enable_in;
		end
	end

	for (genvar i = 1; i < DEPTH; i++) begin : g_stage
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				stage[i] <= '0;
			end else begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign enable_out = stage[DEPTH-1];
endmodule
`default_nettype wire

// ===== dv/pin_strap_model.sv
// Board controller and strap pins that drive the enable, code and mode pins.
`default_nettype none
module pin_strap_model (
	input wire logic rst_n_in,
	input wire logic mode_req_in,
	input wire logic [7:0] enable_n_req_in,
	input wire logic [1:0] code_req_in,
	input wire logic sda_oe_in,
	output logic mode_out,
	output logic [7:0] enable_n_out,
	output logic code0_out,
	output logic code1_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic held;
	// The mode strap is only re-read across a power cycle, modelled by reset.
	always @(posedge rst_n_in) begin
		held = mode_req_in;
	end
	assign mode_out = rst_n_in ? held : mode_req_in;
	assign enable_n_out = enable_n_req_in;
	assign code0_out = code_req_in[0];
	// Open drain: a low from the device wins over the strap or the bus pull-up.
	assign code1_out = sda_oe_in ? 1'b0 : code_req_in[1];
endmodule
`default_nettype wire

// ===== dv/output_enable_control_test.sv
// Self-checking bench of the output enable control.
`include "oe_ctrl_regs.svh"
`default_nettype none
module output_enable_control_test import oe_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] en_n; logic [1:0] code; drive_state_t dis;} row_t;
	logic clk_in = 0, rst_n_in = 0, mode_req = 0, sda_oe, sda_dat, mode, c0, c1;
	logic [7:0] en_req = 8'hFF, en_n;
	logic [1:0] code_req = 2'h3, resp;
	drive_state_t [7:0] drive_state;
	logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0, arvalid = 0, arready, rvalid, rready = 0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [1:0] bresp, rresp;
	int failures = 0, total_checks = 0, cycles = 0;
	row_t rows [6] = '{'{8'h00, 2'h0, DRIVE_PULL_LOW}, '{8'hFF, 2'h0, DRIVE_PULL_LOW},
		'{8'hA5, 2'h1, DRIVE_DIFF_LOW}, '{8'h5A, 2'h2, DRIVE_RESERVED},
		'{8'hFF, 2'h3, DRIVE_HIGH_Z}, '{8'h0F, 2'h3, DRIVE_HIGH_Z}};
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	pin_strap_model strap (.rst_n_in(rst_n_in), .mode_req_in(mode_req), .enable_n_req_in(en_req),
		.code_req_in(code_req), .sda_oe_in(sda_oe), .mode_out(mode), .enable_n_out(en_n),
		.code0_out(c0), .code1_out(c1));
	output_enable_control dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .mode_select_in(mode),
		.per_output_enable_n_in(en_n), .disabled_state_code_bit0_in(c0), .disabled_state_code_bit1_in(c1),
		.disabled_state_code_bit1_out(sda_dat), .disabled_state_code_bit1_oe_out(sda_oe),
		.drive_state_out(drive_state), .axi_awvalid_in(awvalid), .axi_awready_out(awready),
		.axi_awaddr_in(awaddr), .axi_awprot_in(3'h0), .axi_wvalid_in(wvalid), .axi_wready_out(wready),
		.axi_wdata_in(wdata), .axi_wstrb_in(4'hF), .axi_bvalid_out(bvalid), .axi_bready_in(bready),
		.axi_bresp_out(bresp), .axi_arvalid_in(arvalid), .axi_arready_out(arready),
		.axi_araddr_in(araddr), .axi_arprot_in(3'h0), .axi_rvalid_out(rvalid), .axi_rready_in(rready),
		.axi_rdata_out(rdata), .axi_rresp_out(rresp));
	// ----------------------------------------
	// Checking and reporting
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_drive(input logic [23:0] exp);
		chk({8'h00, drive_state}, {8'h00, exp});
	endtask
	function automatic logic [23:0] expect_drive(input logic [7:0] e_n, input drive_state_t dis);
		logic [23:0] v;
		for (int i = 0; i < 8; i++) begin
			v[i*3 +: 3] = e_n[i] ? dis : DRIVE_ACTIVE;
		end
		return v;
	endfunction
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			conclude();
		end
	end
	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_left, w_left;
		@(posedge clk_in);
		awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; bready <= 1;
		aw_left = 1; w_left = 1;
		while (aw_left || w_left) begin
			@(posedge clk_in);
			if (aw_left && awready === 1'b1) begin aw_left = 0; awvalid <= 0; end
			if (w_left && wready === 1'b1) begin w_left = 0; wvalid <= 0; end
		end
		do @(posedge clk_in); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
	endtask
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		arvalid <= 1; araddr <= a; rready <= 1;
		do @(posedge clk_in); while (arready !== 1'b1);
		arvalid <= 0;
		while (rvalid !== 1'b1) @(posedge clk_in);
		d = rdata; r = rresp;
		rready <= 0;
	endtask
	task automatic set_pins(input logic [7:0] e_n, input logic [1:0] code);
		@(posedge clk_in);
		en_req <= e_n; code_req <= code;
	endtask
	task automatic power_cycle(input logic m);
		@(posedge clk_in);
		rst_n_in <= 0; mode_req <= m;
		repeat (16) @(posedge clk_in);
		#1 chk_drive({8{DRIVE_HIGH_Z}});
		chk({29'h0, awready, wready, arready}, 32'h7);
		@(posedge clk_in);
		rst_n_in <= 1;
		repeat (4) @(posedge clk_in);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		power_cycle(1'b0);
		$display("Test reset done");
		foreach (rows[i]) begin
			set_pins(rows[i].en_n, rows[i].code);
			repeat (10) @(posedge clk_in);
			#1 chk_drive(expect_drive(rows[i].en_n, rows[i].dis));
		end
		$display("Test pin table done");
		// A pin change lands at the seventh edge: two sync flops, four delay stages, one output flop.
		set_pins(8'hFF, 2'h3);
		repeat (10) @(posedge clk_in);
		set_pins(8'hDF, 2'h3);
		repeat (6) @(posedge clk_in);
		#1 chk_drive({8{DRIVE_HIGH_Z}});
		repeat (1) @(posedge clk_in);
		#1 chk_drive(expect_drive(8'hDF, DRIVE_HIGH_Z));
		$display("Test enable delay done");
		set_pins(8'h3C, 2'h2);
		repeat (10) @(posedge clk_in);
		axi_read(`REG_STATUS_OFFSET, rd, resp);
		chk(rd, 32'h0000_C2C3);
		axi_read(`REG_CTRL_OFFSET, rd, resp);
		chk(rd, `CTRL_RESET);
		axi_write(`REG_CTRL_OFFSET, 32'hFFFF_FFFF, resp);
		chk({30'h0, resp}, {30'h0, `AXI_RESP_OKAY});
		axi_read(`REG_CTRL_OFFSET, rd, resp);
		chk(rd, `CTRL_WMASK);
		repeat (4) @(posedge clk_in);
		#1 chk({31'h0, sda_oe}, 32'h0);
		chk_drive(expect_drive(8'h3C, DRIVE_RESERVED));
		axi_write(`REG_STATUS_OFFSET, 32'h0, resp);
		chk({30'h0, resp}, {30'h0, `AXI_RESP_OKAY});
		axi_write(4'h8, 32'h1, resp);
		chk({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
		axi_read(4'h8, rd, resp);
		chk(rd, 32'h0);
		chk({30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
		$display("Test registers done");
		// Serial mode: the strap holds the data line high as a pull-up would.
		set_pins(8'h00, 2'h3);
		power_cycle(1'b1);
		axi_write(`REG_CTRL_OFFSET, 32'h0000_030F, resp);
		repeat (10) @(posedge clk_in);
		#1 chk_drive(expect_drive(8'hF0, DRIVE_HIGH_Z));
		axi_read(`REG_STATUS_OFFSET, rd, resp);
		chk(rd & 32'h0000_7000, 32'h0000_7000);
		axi_write(`REG_CTRL_OFFSET, 32'h0001_0100, resp);
		repeat (10) @(posedge clk_in);
		#1 chk({30'h0, sda_oe, sda_dat}, 32'h2);
		chk_drive({8{DRIVE_DIFF_LOW}});
		axi_read(`REG_STATUS_OFFSET, rd, resp);
		chk(rd & 32'h0000_5000, 32'h0000_1000);
		$display("Test serial mode done");
		conclude();
	end
endmodule
`default_nettype wire
